// ===== core/memory_port_bridge_regs.svh
// Purpose: Encodings and counts shared by the memory port bridge files
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef MEMORY_PORT_BRIDGE_REGS_SVH
`define MEMORY_PORT_BRIDGE_REGS_SVH
`define MPB_W128 2'h0
`define MPB_W64 2'h1
`define MPB_W32 2'h3
`define MPB_SH128 3'h4
`define MPB_SH64 3'h3
`define MPB_SH32 3'h2
`define MPB_HOLD_BASE 3'h2
`define MPB_TAG_LO 4
`endif

// ===== core/mpb_pkg.sv
// Purpose: State types of the memory port bridge
// Assumes: Used with scoped names only
// Notes: None
package mpb_pkg;
  typedef enum logic [2:0] {X_IDLE, X_WCOL, X_WAIT, X_ROUT, X_DONE} xb_state_e;
  typedef enum logic [2:0] {L_IDLE, L_ISSUE, L_WDATA, L_RDATA, L_SLOW, L_ACK} lk_state_e;
endpackage

// ===== core/xing_if.sv
// Purpose: Toggle event carried between two clock domains
// Assumes: tog driven in source domain, pulse in destination domain
// Notes: None
`timescale 1ns/10ps
interface xing_if;
  logic tog;
  logic pulse;
  modport src(output tog, input pulse);
  modport sync(input tog, output pulse);
endinterface

// ===== core/toggle_sync.sv
// Purpose: Two-flop toggle synchroniser with event pulse output
// Assumes: Source toggles at most once per handshake
// Notes: pulse lasts one destination clock
`timescale 1ns/10ps
module toggle_sync (
  input wire logic clk_i,
  input wire logic reset_i,
  xing_if.sync x
);
  logic meta_r;
  logic sync_r;
  logic seen_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      meta_r <= x.tog;
      sync_r <= meta_r;
      seen_r <= sync_r;
    end
  end

  assign x.pulse = sync_r ^ seen_r;
endmodule

// ===== core/memory_port_bridge.sv
// Purpose: Bridge crossbar transactions into fixed bursts on the memory port
// Assumes: Crossbar side on mclk_i, memory port side on mem_clk_i
// Notes: Whole transactions cross by toggle handshake with held buffers
`timescale 1ns/10ps
`include "memory_port_bridge_regs.svh"

// Notes on behaviour
// - Fixed burst of 1, 2, 4 or 8
// - Split transactions, new address per burst
// - Port width 128, 64 or 32 bits
// - Works at any 1:N clock ratio
// - Works at 2:3 ratio with extra latency
// - Drive address, strobe, read/write flag
// - Strobe lasts one port cycle per burst
// - Write data follows strobe by 0 to 10
// - Only start address given per burst
// - Started transactions are never aborted
// - Sixteen byte lane enables with write data
// - Narrow writes on low lanes, back to back
// - Narrow reads assembled into full words
// - Address forwarded, no range check
// - Row and bank change flags per burst
// - No new address while controller holds off
// - Brief internal hold after triggering change
// - Back to back, delay only when configured
// - All settings come from configuration ports
// - Hold gap codes give 2 to 5 cycles
// - Width codes 00, 01, 11; 10 reserved
// - Mask bit set marks compared address bit
// - Disabled bridge fails every crossbar access
module memory_port_bridge (
  input wire logic mclk_i,
  input wire logic mem_clk_i,
  input wire logic reset_i,
  input wire logic cfg_enable_i,
  input wire logic cfg_row_hold_en_i,
  input wire logic cfg_bank_hold_en_i,
  input wire logic cfg_dir_hold_en_i,
  input wire logic [1:0] cfg_hold_gap_i,
  input wire logic cfg_frac_ratio_i,
  input wire logic [1:0] cfg_width_i,
  input wire logic [1:0] cfg_burst_len_i,
  input wire logic [3:0] cfg_write_data_delay_i,
  input wire logic [31:0] cfg_row_mask_i,
  input wire logic [31:0] cfg_bank_mask_i,
  input wire logic xb_cmd_valid_i,
  output logic xb_cmd_ready_o,
  input wire logic [35:0] xb_addr_i,
  input wire logic xb_rnw_i,
  input wire logic [3:0] xb_words_i,
  input wire logic xb_wvalid_i,
  output logic xb_wready_o,
  input wire logic [127:0] xb_wdata_i,
  input wire logic [15:0] xb_wbe_i,
  output logic xb_rvalid_o,
  output logic [127:0] xb_rdata_o,
  output logic xb_done_o,
  output logic xb_err_o,
  output logic [35:0] txn_addr_out_o,
  output logic addr_strobe_out_o,
  output logic rd_not_wr_flag_o,
  output logic [127:0] wr_data_out_o,
  output logic [15:0] byte_lane_enables_o,
  output logic row_change_flag_o,
  output logic bank_change_flag_o,
  input wire logic [127:0] rd_data_in_i,
  input wire logic rd_data_valid_in_i,
  input wire logic ctrl_hold_off_in_i
);
  // Beat size as a byte shift for a width code
  function automatic logic [2:0] beat_shift(input logic [1:0] code);
    case (code)
      `MPB_W64: beat_shift = `MPB_SH64;
      `MPB_W32: beat_shift = `MPB_SH32;
      default: beat_shift = `MPB_SH128;
    endcase
  endfunction

  mpb_pkg::xb_state_e xs_r;
  mpb_pkg::lk_state_e ls_r;
  logic [127:0] wbuf_r [0:15];
  logic [15:0] wbe_r [0:15];
  logic [127:0] rbuf_r [0:15];
  logic [35:0] cmd_addr_r;
  logic cmd_rnw_r;
  logic [3:0] cmd_words_r;
  logic [1:0] cmd_width_r;
  logic [1:0] cmd_bl_r;
  logic [1:0] cmd_gap_r;
  logic [3:0] cmd_wdd_r;
  logic [2:0] cmd_hold_en_r;
  logic cmd_frac_r;
  logic [31:0] cmd_row_mask_r;
  logic [31:0] cmd_bank_mask_r;
  logic [3:0] wptr_r;
  logic req_tog_r;
  logic ack_tog_r;
  logic [35:0] taddr_r;
  logic [35:0] prev_addr_r;
  logic prev_rnw_r;
  logic first_r;
  logic [6:0] beat_r;
  logic [2:0] bcnt_r;
  logic [3:0] dcnt_r;
  logic [2:0] gap_r;
  logic wbeat_q;
  logic [2:0] shift;
  logic [8:0] total_beats;
  logic [3:0] blen;
  logic [7:0] burst_bytes;
  logic issue_go;
  logic emit;
  logic step;
  logic burst_end;
  logic last_beat;
  logic row_chg;
  logic bank_chg;
  logic hazard;
  logic [35:0] adiff;
  logic [10:0] boff;
  logic [3:0] widx;
  logic [3:0] lane;
  logic [127:0] beat_data;
  logic [15:0] beat_be;

  xing_if req_x();
  xing_if ack_x();
  assign req_x.tog = req_tog_r;
  assign ack_x.tog = ack_tog_r;

  // Command toward the port domain, completion back
  toggle_sync u_req_sync (
    .clk_i(mem_clk_i),
    .reset_i(reset_i),
    .x(req_x.sync)
  );
  toggle_sync u_ack_sync (
    .clk_i(mclk_i),
    .reset_i(reset_i),
    .x(ack_x.sync)
  );

  // Crossbar side sequencing
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      xs_r <= mpb_pkg::X_IDLE;
      xb_cmd_ready_o <= 1'b1;
      xb_wready_o <= 1'b0;
      xb_rvalid_o <= 1'b0;
      xb_rdata_o <= '0;
      xb_done_o <= 1'b0;
      xb_err_o <= 1'b0;
      req_tog_r <= 1'b0;
      wptr_r <= '0;
    end else begin
      xb_rvalid_o <= 1'b0;
      xb_done_o <= 1'b0;
      xb_err_o <= 1'b0;
      case (xs_r)
        mpb_pkg::X_IDLE: begin
          if (xb_cmd_valid_i) begin
            xb_cmd_ready_o <= 1'b0;
            wptr_r <= '0;
            if (!cfg_enable_i) begin
              xb_err_o <= 1'b1;
              xs_r <= mpb_pkg::X_DONE;
            end else if (xb_rnw_i) begin
              req_tog_r <= ~req_tog_r;
              xs_r <= mpb_pkg::X_WAIT;
            end else begin
              xb_wready_o <= 1'b1;
              xs_r <= mpb_pkg::X_WCOL;
            end
          end
        end
        mpb_pkg::X_WCOL: begin
          if (xb_wvalid_i) begin
            if (wptr_r == cmd_words_r) begin
              xb_wready_o <= 1'b0;
              req_tog_r <= ~req_tog_r;
              xs_r <= mpb_pkg::X_WAIT;
            end else begin
              wptr_r <= wptr_r + 4'h1;
            end
          end
        end
        mpb_pkg::X_WAIT: begin
          if (ack_x.pulse) begin
            wptr_r <= '0;
            xs_r <= cmd_rnw_r ? mpb_pkg::X_ROUT : mpb_pkg::X_DONE;
          end
        end
        mpb_pkg::X_ROUT: begin
          xb_rvalid_o <= 1'b1;
          xb_rdata_o <= rbuf_r[wptr_r];
          wptr_r <= wptr_r + 4'h1;
          if (wptr_r == cmd_words_r) begin
            xs_r <= mpb_pkg::X_DONE;
          end
        end
        mpb_pkg::X_DONE: begin
          xb_done_o <= 1'b1;
          xb_cmd_ready_o <= 1'b1;
          xs_r <= mpb_pkg::X_IDLE;
        end
        default: begin
          xs_r <= mpb_pkg::X_IDLE;
        end
      endcase
    end
  end

  // Settings snapshot per command, held stable across the handshake
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_addr_r <= '0;
      cmd_rnw_r <= 1'b0;
      cmd_words_r <= '0;
      cmd_width_r <= `MPB_W128;
      cmd_bl_r <= '0;
      cmd_gap_r <= '0;
      cmd_wdd_r <= '0;
      cmd_hold_en_r <= '0;
      cmd_frac_r <= 1'b0;
      cmd_row_mask_r <= '0;
      cmd_bank_mask_r <= '0;
    end else if (xs_r == mpb_pkg::X_IDLE && xb_cmd_valid_i) begin
      cmd_addr_r <= xb_addr_i;
      cmd_rnw_r <= xb_rnw_i;
      cmd_words_r <= xb_words_i;
      cmd_width_r <= cfg_width_i;
      cmd_bl_r <= cfg_burst_len_i;
      cmd_gap_r <= cfg_hold_gap_i;
      cmd_wdd_r <= cfg_write_data_delay_i;
      cmd_hold_en_r <= {cfg_dir_hold_en_i, cfg_bank_hold_en_i, cfg_row_hold_en_i};
      cmd_frac_r <= cfg_frac_ratio_i;
      cmd_row_mask_r <= cfg_row_mask_i;
      cmd_bank_mask_r <= cfg_bank_mask_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (xs_r == mpb_pkg::X_WCOL && xb_wvalid_i) begin
      wbuf_r[wptr_r] <= xb_wdata_i;
      wbe_r[wptr_r] <= xb_wbe_i;
    end
  end

  // Port side decode
  always_comb begin
    shift = beat_shift(cmd_width_r);
    total_beats = {5'({1'b0, cmd_words_r} + 5'h01), 4'h0} >> shift;
    blen = 4'h1 << cmd_bl_r;
    burst_bytes = 8'({4'h0, blen} << shift);
    issue_go = (ls_r == mpb_pkg::L_ISSUE) && (gap_r == 3'h0) && !ctrl_hold_off_in_i;
    emit = !cmd_rnw_r && ((issue_go && cmd_wdd_r == 4'h0) ||
      (ls_r == mpb_pkg::L_WDATA && dcnt_r >= cmd_wdd_r));
    step = emit || (ls_r == mpb_pkg::L_RDATA && rd_data_valid_in_i);
    burst_end = step && (bcnt_r == 3'(blen - 4'h1));
    last_beat = ({2'h0, beat_r} + 9'h001) >= total_beats;
    adiff = taddr_r ^ prev_addr_r;
    row_chg = |(adiff[35:`MPB_TAG_LO] & cmd_row_mask_r);
    bank_chg = |(adiff[35:`MPB_TAG_LO] & cmd_bank_mask_r);
    hazard = !first_r && ((cmd_hold_en_r[0] && row_chg) || (cmd_hold_en_r[1] && bank_chg) ||
      (cmd_hold_en_r[2] && (cmd_rnw_r != prev_rnw_r)));
    boff = {4'h0, beat_r} << shift;
    widx = boff[7:4];
    lane = boff[3:0];
    beat_data = '0;
    beat_be = '0;
    if ({2'h0, beat_r} < total_beats) begin
      case (cmd_width_r)
        `MPB_W64: begin
          beat_data[63:0] = wbuf_r[widx][{lane, 3'h0} +: 64];
          beat_be[7:0] = wbe_r[widx][lane +: 8];
        end
        `MPB_W32: begin
          beat_data[31:0] = wbuf_r[widx][{lane, 3'h0} +: 32];
          beat_be[3:0] = wbe_r[widx][lane +: 4];
        end
        default: begin
          beat_data = wbuf_r[widx];
          beat_be = wbe_r[widx];
        end
      endcase
    end
  end

  // Port side sequencing; a burst once started always runs to its end
  always_ff @(posedge mem_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ls_r <= mpb_pkg::L_IDLE;
      taddr_r <= '0;
      beat_r <= '0;
      bcnt_r <= '0;
      ack_tog_r <= 1'b0;
    end else begin
      case (ls_r)
        mpb_pkg::L_IDLE: begin
          if (req_x.pulse) begin
            taddr_r <= cmd_addr_r;
            beat_r <= '0;
            bcnt_r <= '0;
            ls_r <= mpb_pkg::L_ISSUE;
          end
        end
        mpb_pkg::L_ISSUE, mpb_pkg::L_WDATA, mpb_pkg::L_RDATA: begin
          if (burst_end) begin
            bcnt_r <= '0;
            beat_r <= beat_r + 7'h01;
            if (last_beat) begin
              ls_r <= cmd_frac_r ? mpb_pkg::L_SLOW : mpb_pkg::L_ACK;
            end else begin
              taddr_r <= taddr_r + 36'(burst_bytes);
              ls_r <= mpb_pkg::L_ISSUE;
            end
          end else begin
            if (step) begin
              beat_r <= beat_r + 7'h01;
              bcnt_r <= bcnt_r + 3'h1;
            end
            if (issue_go) begin
              ls_r <= cmd_rnw_r ? mpb_pkg::L_RDATA : mpb_pkg::L_WDATA;
            end
          end
        end
        mpb_pkg::L_SLOW: begin
          ls_r <= mpb_pkg::L_ACK;
        end
        mpb_pkg::L_ACK: begin
          ack_tog_r <= ~ack_tog_r;
          ls_r <= mpb_pkg::L_IDLE;
        end
        default: begin
          ls_r <= mpb_pkg::L_IDLE;
        end
      endcase
    end
  end

  // Delay from strobe to first write beat
  always_ff @(posedge mem_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dcnt_r <= '0;
    end else if (issue_go) begin
      dcnt_r <= 4'h1;
    end else if (ls_r == mpb_pkg::L_WDATA && dcnt_r < cmd_wdd_r) begin
      dcnt_r <= dcnt_r + 4'h1;
    end
  end

  // Internal hold window after a triggering change
  always_ff @(posedge mem_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_r <= '0;
    end else if (issue_go) begin
      gap_r <= hazard ? 3'(`MPB_HOLD_BASE + {1'b0, cmd_gap_r}) : 3'h0;
    end else if (gap_r != 3'h0) begin
      gap_r <= gap_r - 3'h1;
    end
  end

  // Port outputs
  always_ff @(posedge mem_clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_strobe_out_o <= 1'b0;
      txn_addr_out_o <= '0;
      rd_not_wr_flag_o <= 1'b0;
      row_change_flag_o <= 1'b0;
      bank_change_flag_o <= 1'b0;
      wr_data_out_o <= '0;
      byte_lane_enables_o <= '0;
      prev_addr_r <= '0;
      prev_rnw_r <= 1'b0;
      first_r <= 1'b1;
      wbeat_q <= 1'b0;
    end else begin
      addr_strobe_out_o <= issue_go;
      wr_data_out_o <= emit ? beat_data : '0;
      byte_lane_enables_o <= emit ? beat_be : '0;
      wbeat_q <= emit;
      if (issue_go) begin
        txn_addr_out_o <= taddr_r;
        rd_not_wr_flag_o <= cmd_rnw_r;
        row_change_flag_o <= row_chg;
        bank_change_flag_o <= bank_chg;
        prev_addr_r <= taddr_r;
        prev_rnw_r <= cmd_rnw_r;
        first_r <= 1'b0;
      end
    end
  end

  // Narrow read beats placed into full words
  always_ff @(posedge mem_clk_i) begin
    if (ls_r == mpb_pkg::L_RDATA && rd_data_valid_in_i && {2'h0, beat_r} < total_beats) begin
      case (cmd_width_r)
        `MPB_W64: rbuf_r[widx][{lane, 3'h0} +: 64] <= rd_data_in_i[63:0];
        `MPB_W32: rbuf_r[widx][{lane, 3'h0} +: 32] <= rd_data_in_i[31:0];
        default: rbuf_r[widx] <= rd_data_in_i;
      endcase
    end
  end

  AST_RD_STROBE_ONE: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    addr_strobe_out_o && rd_not_wr_flag_o |=> !addr_strobe_out_o)
    else $error("read strobe longer than one cycle");
  AST_HOLD_OFF: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    addr_strobe_out_o |-> !$past(ctrl_hold_off_in_i))
    else $error("strobe issued during hold-off");
  AST_WDD_ZERO: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    addr_strobe_out_o && !rd_not_wr_flag_o && cmd_wdd_r == 4'h0 |-> wbeat_q)
    else $error("write data late with zero delay");
  AST_WDD_THREE: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    addr_strobe_out_o && !rd_not_wr_flag_o && cmd_wdd_r == 4'h3 |-> !wbeat_q ##3 wbeat_q)
    else $error("write data not three cycles after strobe");
  AST_NARROW_LANES: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    wbeat_q && cmd_width_r == `MPB_W32 |-> wr_data_out_o[127:32] == '0 &&
      byte_lane_enables_o[15:4] == '0)
    else $error("narrow write outside low lanes");
  AST_ADDR_STEP: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    issue_go && beat_r != 7'h00 |-> taddr_r == prev_addr_r + 36'(burst_bytes))
    else $error("burst address step wrong");
  AST_ROW_SAME: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    issue_go && ((taddr_r[35:4] ^ prev_addr_r[35:4]) & cmd_row_mask_r) == '0
      |=> !row_change_flag_o)
    else $error("row flag without masked change");
  AST_GAP_HOLD: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    issue_go && hazard |=> !issue_go [*2])
    else $error("address released inside hold window");
  AST_NO_ABORT: assert property (@(posedge mem_clk_i) disable iff (reset_i)
    ls_r == mpb_pkg::L_WDATA && !burst_end |=> ls_r == mpb_pkg::L_WDATA)
    else $error("write burst cut short");
  AST_DISABLED_FAIL: assert property (@(posedge mclk_i) disable iff (reset_i)
    xb_cmd_valid_i && xb_cmd_ready_o && !cfg_enable_i |=> xb_err_o ##1 xb_done_o)
    else $error("disabled access not failed");

  COV_WRITE_DONE: cover property (@(posedge mclk_i) disable iff (reset_i)
    xs_r == mpb_pkg::X_WAIT && !cmd_rnw_r && ack_x.pulse);
  COV_READ_DONE: cover property (@(posedge mclk_i) disable iff (reset_i)
    xs_r == mpb_pkg::X_ROUT && wptr_r == cmd_words_r);
  COV_HOLD_GAP: cover property (@(posedge mem_clk_i) disable iff (reset_i)
    issue_go && hazard);
  COV_NARROW_READ: cover property (@(posedge mem_clk_i) disable iff (reset_i)
    step && cmd_rnw_r && cmd_width_r == `MPB_W32);
endmodule

// ===== verification/mem_ctrl_model.sv
// Purpose: Soft memory controller model on the port side
// Assumes: Width, burst and delay mirror the bridge settings
// Notes: Unwritten bytes read back as the inverted address byte
`timescale 1ns/10ps
module mem_ctrl_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic stb_i,
  input wire logic rnw_i,
  input wire logic [35:0] addr_i,
  input wire logic [127:0] wdata_i,
  input wire logic [15:0] be_i,
  input wire logic row_i,
  input wire logic [1:0] width_i,
  input wire logic [1:0] bl_i,
  input wire logic [3:0] wdd_i,
  input wire logic slow_i,
  input wire logic hold_i,
  output logic [127:0] rdata_o,
  output logic rvalid_o,
  output logic hold_o
);
  logic [7:0] mem [logic [35:0]];
  logic [35:0] wq [$];
  logic [35:0] rq [$];
  logic [35:0] a;
  int wdue [$];
  int cyc, bb, bl, rb, rw, hold_cnt;
  logic auto_hold;
  // auto_hold is registered so the bridge never races the model at a port edge; hold_i passes through unregistered
  assign hold_o = hold_i || auto_hold;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc = 0;
      hold_cnt = 0;
      auto_hold <= 1'h0;
      rb = 0;
      wq.delete();
      wdue.delete();
      rq.delete();
      rvalid_o <= 1'h0;
      rdata_o <= '0;
    end else begin
      bb = width_i == 2'h1 ? 8 : width_i == 2'h3 ? 4 : 16;
      bl = 1 << bl_i;
      cyc++;
      hold_cnt = hold_cnt > 0 ? hold_cnt - 1 : 0;
      if (stb_i) begin
        if (row_i) hold_cnt = 4;
        if (rnw_i) rq.push_back(addr_i);
        else begin
          wq.push_back(addr_i);
          wdue.push_back(cyc + wdd_i);
        end
      end
      auto_hold <= hold_cnt > 0;
      // Own address advance within a burst
      if (wq.size() > 0 && cyc >= wdue[0]) begin
        a = wq[0] + 36'((cyc - wdue[0]) * bb);
        for (int i = 0; i < bb; i++) if (be_i[i]) mem[a + 36'(i)] = wdata_i[8*i +: 8];
        if (cyc - wdue[0] == bl - 1) begin
          wq.pop_front();
          wdue.pop_front();
        end
      end
      // Idle read lines keep changing
      rvalid_o <= 1'h0;
      rdata_o <= ~rdata_o;
      if (rb == 0 && rq.size() > 0) begin
        rb = bl;
        rw = slow_i ? 3 : 0;
      end
      if (rb > 0 && rw > 0) rw--;
      else if (rb > 0) begin
        a = rq[0] + 36'((bl - rb) * bb);
        for (int i = 0; i < bb; i++)
          rdata_o[8*i +: 8] <= mem.exists(a + 36'(i)) ? mem[a + 36'(i)] : ~8'(a + 36'(i));
        rvalid_o <= 1'h1;
        rb--;
        if (rb == 0) rq.pop_front();
      end
    end
  end
endmodule

// ===== verification/memory_port_bridge_test.sv
// Purpose: Self-checking bench for the memory port bridge
// Assumes: Bridge and controller model share one configuration
// Notes: Stimulus changes at falling mclk edges
`timescale 1ns/10ps
module memory_port_bridge_test;
  logic mclk_i = 1'h0, mem_clk_i = 1'h0, reset_i = 1'h1, hold_req = 1'h0;
  logic cfg_enable_i = '0, cfg_row_hold_en_i = '0, cfg_bank_hold_en_i = '0;
  logic cfg_dir_hold_en_i = '0, cfg_frac_ratio_i = '0, xb_cmd_valid_i = '0;
  logic xb_rnw_i = '0, xb_wvalid_i = '0, got_err, last_row, last_bank;
  logic [1:0] cfg_hold_gap_i = '0, cfg_width_i = '0, cfg_burst_len_i = '0;
  logic [3:0] cfg_write_data_delay_i = '0, xb_words_i = '0;
  logic [31:0] cfg_row_mask_i = '0, cfg_bank_mask_i = '0;
  logic [35:0] xb_addr_i = '0, base = '0, a;
  logic [127:0] xb_wdata_i = '0, exp;
  logic [15:0] xb_wbe_i = '0;
  logic [127:0] wq [2];
  logic [15:0] bq [2];
  logic [127:0] rq [$];
  wire logic xb_cmd_ready_o, xb_wready_o, xb_rvalid_o, xb_done_o, xb_err_o;
  wire logic addr_strobe_out_o, rd_not_wr_flag_o, row_change_flag_o, bank_change_flag_o;
  wire logic rd_data_valid_in_i, ctrl_hold_off_in_i;
  wire logic [127:0] xb_rdata_o, wr_data_out_o, rd_data_in_i;
  wire logic [35:0] txn_addr_out_o;
  wire logic [15:0] byte_lane_enables_o;
  int errors = 0, compares = 0, cyc = 0, mcyc = 0, nstb = 0, last_stb, min_gap = 0, step, idx = 0;

  memory_port_bridge memory_port_bridge_inst (.mclk_i, .mem_clk_i, .reset_i, .cfg_enable_i,
    .cfg_row_hold_en_i, .cfg_bank_hold_en_i, .cfg_dir_hold_en_i, .cfg_hold_gap_i,
    .cfg_frac_ratio_i, .cfg_width_i, .cfg_burst_len_i, .cfg_write_data_delay_i,
    .cfg_row_mask_i, .cfg_bank_mask_i, .xb_cmd_valid_i, .xb_cmd_ready_o, .xb_addr_i,
    .xb_rnw_i, .xb_words_i, .xb_wvalid_i, .xb_wready_o, .xb_wdata_i, .xb_wbe_i,
    .xb_rvalid_o, .xb_rdata_o, .xb_done_o, .xb_err_o, .txn_addr_out_o, .addr_strobe_out_o,
    .rd_not_wr_flag_o, .wr_data_out_o, .byte_lane_enables_o, .row_change_flag_o,
    .bank_change_flag_o, .rd_data_in_i, .rd_data_valid_in_i, .ctrl_hold_off_in_i);

  mem_ctrl_model mem_ctrl_model_inst (.clk_i(mem_clk_i), .reset_i, .stb_i(addr_strobe_out_o),
    .rnw_i(rd_not_wr_flag_o), .addr_i(txn_addr_out_o), .wdata_i(wr_data_out_o),
    .be_i(byte_lane_enables_o), .row_i(row_change_flag_o), .width_i(cfg_width_i),
    .bl_i(cfg_burst_len_i), .wdd_i(cfg_write_data_delay_i), .slow_i(cfg_frac_ratio_i),
    .hold_i(hold_req), .rdata_o(rd_data_in_i), .rvalid_o(rd_data_valid_in_i),
    .hold_o(ctrl_hold_off_in_i));

  initial forever #2.5 mclk_i = ~mclk_i;
  initial begin
    #6.3;
    forever #24 mem_clk_i = ~mem_clk_i;
  end

  task automatic chk_data(input logic [127:0] got, input logic [127:0] want, input string m);
    compares++;
    if (got !== want) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic chk_bit(input logic got, input logic want, input string m);
    chk_data(128'(got), 128'(want), m);
  endtask

  task automatic summarize;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      $display("[FAIL] %0t run too long", $time);
      summarize();
    end
  end

  // Port-side monitor
  always @(negedge mem_clk_i) begin
    mcyc++;
    if (addr_strobe_out_o === 1'h1) begin
      chk_data(128'(txn_addr_out_o), 128'(base + 36'(nstb * step)), "address");
      chk_bit(rd_not_wr_flag_o, xb_rnw_i, "direction flag");
      if (min_gap > 0 && nstb > 0) chk_bit(mcyc - last_stb >= min_gap, 1'h1, "gap");
      last_row = row_change_flag_o;
      last_bank = bank_change_flag_o;
      last_stb = mcyc;
      nstb++;
    end
  end

  // One crossbar command, entered and left at a falling edge
  task automatic xfer(input logic [35:0] adr, input logic r, input int n);
    int t;
    int bb;
    bb = cfg_width_i == 2'h1 ? 8 : cfg_width_i == 2'h3 ? 4 : 16;
    step = bb << cfg_burst_len_i;
    base = adr;
    nstb = 0;
    got_err = 1'h0;
    rq.delete();
    xb_cmd_valid_i = 1'h1;
    xb_addr_i = adr;
    xb_rnw_i = r;
    xb_words_i = 4'(n);
    do @(posedge mclk_i); while (xb_cmd_ready_o !== 1'h1);
    @(negedge mclk_i);
    xb_cmd_valid_i = 1'h0;
    for (int k = 0; k <= n && !r && cfg_enable_i; k++) begin
      xb_wvalid_i = 1'h1;
      xb_wdata_i = wq[k];
      xb_wbe_i = bq[k];
      do @(posedge mclk_i); while (xb_wready_o !== 1'h1);
      @(negedge mclk_i);
    end
    xb_wvalid_i = 1'h0;
    for (t = 0; t < 20000; t++) begin
      if (xb_rvalid_o === 1'h1) rq.push_back(xb_rdata_o);
      if (xb_err_o === 1'h1) got_err = 1'h1;
      if (xb_done_o === 1'h1) break;
      @(negedge mclk_i);
    end
    chk_bit(t < 20000, 1'h1, "command never completed");
    chk_bit(got_err, !cfg_enable_i, "error pulse");
    chk_data(128'(nstb), cfg_enable_i ? 128'(((n + 1) * 16 + step - 1) / step) : '0,
      "strobe count");
  endtask

  initial begin
    repeat (3) @(posedge mem_clk_i);
    @(negedge mclk_i);
    reset_i = 1'h0;
    wq = '{'0, '0};
    bq = '{16'hFFFF, 16'hFFFF};
    xfer(36'h0, 1'h0, 0);
    xfer(36'h0, 1'h1, 0);
    cfg_enable_i = 1'h1;
    for (int f = 0; f < 2; f++)
      for (int w = 0; w < 3; w++)
        for (int b = 0; b < 4; b++) begin
          idx++;
          cfg_frac_ratio_i = f[0];
          cfg_width_i = w == 2 ? 2'h3 : 2'(w);
          cfg_burst_len_i = 2'(b);
          cfg_write_data_delay_i = 4'((w * 4 + b) * 3 % 11);
          for (int k = 0; k < 2; k++)
            for (int j = 0; j < 16; j++) wq[k][8*j +: 8] = 8'(idx * 7 + k * 16 + j);
          bq = '{16'hFFFF, 16'h5A3C};
          a = 36'h8_0000_0000 + 36'(idx * 256);
          xfer(a, 1'h0, 1);
          xfer(a, 1'h1, 1);
          chk_data(128'(rq.size()), 128'h2, "read word count");
          for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 16; j++)
              exp[8*j +: 8] = bq[k][j] ? wq[k][8*j +: 8] : ~8'(a + 36'(16 * k + j));
            chk_data(rq[k], exp, "read word");
          end
          chk_bit(last_row, 1'h0, "row flag with empty mask");
        end
    hold_req = 1'h1;
    fork
      xfer(36'h0_0000_0040, 1'h0, 0);
      begin
        repeat (30) @(negedge mem_clk_i);
        chk_data(128'(nstb), '0, "strobe while held off");
        @(negedge mclk_i);
        hold_req = 1'h0;
      end
    join
    cfg_frac_ratio_i = 1'h0;
    cfg_width_i = 2'h0;
    cfg_burst_len_i = 2'h0;
    cfg_write_data_delay_i = 4'h0;
    cfg_bank_hold_en_i = 1'h1;
    cfg_bank_mask_i = 32'h1;
    for (int g = 0; g < 4; g++) begin
      cfg_hold_gap_i = 2'(g);
      cfg_row_mask_i = {30'h0, g[0], 1'h0};
      min_gap = g + 3;
      xfer(36'h7_0000_0010 + 36'(g * 64), 1'h0, 1);
      chk_bit(last_bank, 1'h1, "bank change flag");
      chk_bit(last_row, g[0], "row change flag");
    end
    cfg_bank_hold_en_i = 1'h0;
    cfg_dir_hold_en_i = 1'h1;
    min_gap = 6;
    xfer(36'h7_0000_0010, 1'h1, 1);
    chk_data(rq[0], wq[0], "read after direction turn");
    summarize();
  end
endmodule
